// ---- verilog/frc_cfg.svh ----
// constants for the row change and block erase command state machine
`ifndef FRC_CFG_SVH
`define FRC_CFG_SVH

// register byte offsets on the wishbone slave
`define FRC_OFS_CTRL      8'h00
`define FRC_OFS_STATUS    8'h04
`define FRC_OFS_RETURN    8'h08
`define FRC_OFS_ROWADDR   8'h0c

// control register fields
`define FRC_CTRL_STATOUT  0
`define FRC_CTRL_ENHCLR   1

// status register fields
`define FRC_ST_STATE_LSB  0
`define FRC_ST_CMD_LSB    12
`define FRC_ST_UNIT_LSB   20
`define FRC_ST_ENH        22
`define FRC_ST_RB         23

// reset values
`define FRC_RST_CMD       8'h00
`define FRC_RST_STATOUT   1'b0

// address layout: row cycles per row address, unit index position
`define FRC_ROW_CYCLES    2'd3
`define FRC_ROW_W         24
`define FRC_UNIT_W        2
`define FRC_UNIT_LSB      22

// command cycle codes
`define FRC_CMD_READ      8'h00
`define FRC_CMD_ERASE     8'h60
`define FRC_CMD_STATUS    8'h70
`define FRC_CMD_ENHSTAT   8'h78
`define FRC_CMD_ERASE_GO  8'hd0
`define FRC_CMD_ERASE_ILV 8'hd1

`endif

// ---- verilog/frc_pkg.sv ----
// types shared by the row change and block erase command state machine
package frc_pkg;

  // one-hot controller states
  typedef enum logic [11:0] {
    ST_IDLE        = 12'h001,
    ST_COL_WAIT    = 12'h002,  // program_column_change_wait
    ST_ROW_WAIT    = 12'h004,  // program_row_change_wait
    ST_ROW_STORE   = 12'h008,  // program_row_addr_store
    ST_ROW_REQ     = 12'h010,  // program_row_change_request
    ST_DOUT_WAIT   = 12'h020,  // program_data_out_wait
    ST_ER_EXEC     = 12'h040,  // erase_execute
    ST_ER_STORE    = 12'h080,  // erase_addr_store
    ST_ER_UNIT     = 12'h100,  // erase_unit_execute
    ST_ER_CONFIRM  = 12'h200,  // erase_confirm_wait
    ST_ER_PASS     = 12'h400,  // erase_command_pass
    ST_ER_ILV      = 12'h800   // erase_interleave_wait
  } frc_state_t;

  // states outside this block that a hand-off names
  typedef enum logic [3:0] {
    EX_NONE        = 4'h0,
    EX_IDLE        = 4'h1,
    EX_PROG_DATA   = 4'h2,  // program_data_wait
    EX_PROG_ILV    = 4'h3,  // program_interleave_wait
    EX_STATUS_OUT  = 4'h4,  // status output
    EX_UNIT_DATA   = 4'h5,  // idle_unit_data_output
    EX_READ_STAT   = 4'h6,  // read_status_execute
    EX_ENH_STAT    = 4'h7,  // enhanced_status_execute
    EX_READ_EXEC   = 4'h8,
    EX_COL_OTHER   = 4'h9   // column change wait left by data or command
  } frc_exit_t;

endpackage : frc_pkg

// ---- verilog/frc_reg_if.sv ----
// carrier between the command controller and its register bank
`timescale 1ns/10ps
`include "frc_cfg.svh"
interface frc_reg_if;
  frc_pkg::frc_state_t     state;           // current controller state
  frc_pkg::frc_state_t     saved_return_state;
  logic [7:0]              last_command_code;
  logic [`FRC_UNIT_W-1:0]  selected_unit_index;
  logic                    enhanced_status_required;
  logic                    rb_level;        // filtered ready/busy level
  logic [`FRC_ROW_W-1:0]   row_addr;
  logic                    status_output_flag;
  logic                    enh_clr;         // one-cycle clear request

  modport core (
    output state, saved_return_state, last_command_code, selected_unit_index,
    output enhanced_status_required, rb_level, row_addr,
    input  status_output_flag, enh_clr
  );
  modport regs (
    input  state, saved_return_state, last_command_code, selected_unit_index,
    input  enhanced_status_required, rb_level, row_addr,
    output status_output_flag, enh_clr
  );
endinterface : frc_reg_if

// ---- verilog/frc_regs.sv ----
// classic wishbone register bank of the command controller
`timescale 1ns/10ps
`include "frc_cfg.svh"
module frc_regs (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  frc_reg_if.regs          rif
);

  logic        statout_r;  // status output flag, software owned
  logic        enh_clr_r;  // clear pulse toward the core
  logic [31:0] rdata_nxt;  // read mux
  logic        take;       // request taken this edge

  // one answer per request: ack rises a cycle after strobe, drops next
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // read mux; unmapped offsets read as zero and still ack
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `FRC_OFS_CTRL:    rdata_nxt[`FRC_CTRL_STATOUT] = statout_r;
      `FRC_OFS_STATUS: begin
        rdata_nxt[`FRC_ST_STATE_LSB +: 12]        = rif.state;
        rdata_nxt[`FRC_ST_CMD_LSB +: 8]           = rif.last_command_code;
        rdata_nxt[`FRC_ST_UNIT_LSB +: `FRC_UNIT_W] = rif.selected_unit_index;
        rdata_nxt[`FRC_ST_ENH]                    = rif.enhanced_status_required;
        rdata_nxt[`FRC_ST_RB]                     = rif.rb_level;
      end
      `FRC_OFS_RETURN:  rdata_nxt[11:0] = rif.saved_return_state;
      `FRC_OFS_ROWADDR: rdata_nxt[`FRC_ROW_W-1:0] = rif.row_addr;
      default:          rdata_nxt = 32'h0000_0000;
    endcase
  end

  // bus answer registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= take;
      if (take && !wb_we_i) wb_dat_o <= rdata_nxt;
    end
  end

  // control writes; byte lane 0 carries both control bits
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      statout_r <= `FRC_RST_STATOUT;
      enh_clr_r <= 1'b0;
    end else begin
      enh_clr_r <= 1'b0;
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == `FRC_OFS_CTRL) begin
        statout_r <= wb_dat_i[`FRC_CTRL_STATOUT];
        enh_clr_r <= wb_dat_i[`FRC_CTRL_ENHCLR];
      end
    end
  end

  assign rif.status_output_flag = statout_r;
  assign rif.enh_clr            = enh_clr_r;

endmodule : frc_regs

// ---- verilog/frc_ctrl.sv ----
// row change, data-out wait and block erase command state machine
// Notes on behaviour
// [R1] column change wait: address starts row change
// [R2] row change wait: address cycle goes to store
// [R3] store row cycles, loop until all arrived
// [R4] ask selected unit to adopt row, then wait
// [R5] host keeps unit and interleave address unchanged
// [R6] data-out wait records itself as return state
// [R7] read request: status output or unit data
// [R8] 70h, 78h, 00h; other command to interleave
// [R9] host sends 78h then 00h before data
// [R10] erase entry records 60h, waits for row
// [R11] erase entry flags enhanced status when busy
// [R12] store erase row cycles, loop until complete
// [R13] select unit named by row address
// [R14] hand erase with row to unit, confirm
// [R15] wait for d0h or d1h confirm command
// [R16] pass confirm; d1h interleave wait, d0h idle
// [R17] interleave erase wait records return state
// [R18] 60h in interleave wait starts next erase
// [R19] 70h read status, 78h enhanced status
// [R20] read with status output goes status output
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "frc_cfg.svh"
module frc_ctrl (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // host cycles, decoded by same-clock logic
  input  wire logic                  host_cmd_valid,
  input  wire logic                  host_addr_valid,
  input  wire logic                  host_data_valid,
  input  wire logic                  host_read_req,
  input  wire logic [7:0]            host_byte,
  // entries from the rest of the target controller
  input  wire logic                  enter_col_wait,
  input  wire logic                  enter_dout_wait,
  // ready/busy pin level, asynchronous
  input  wire logic                  rb_pin,
  // requests toward the logical units
  output logic                       unit_row_change_req,
  output logic                       unit_erase_req,
  output logic                       unit_cmd_pass,
  output logic [7:0]                 unit_cmd,
  output logic [`FRC_UNIT_W-1:0]     unit_sel,
  output logic [`FRC_ROW_W-1:0]      unit_row_addr,
  // hand-off to states kept elsewhere
  output logic                       exit_valid,
  output logic [3:0]                 exit_code,
  output logic                       busy,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o
);

  frc_reg_if rif ();
  frc_pkg::frc_state_t     state_r;        // current state
  frc_pkg::frc_state_t     state_nxt;      // next state
  frc_pkg::frc_state_t     ret_r;          // saved_return_state
  logic [7:0]              cmd_last_r;     // last_command_code
  logic [`FRC_UNIT_W-1:0]  unit_r;         // selected_unit_index
  logic                    enh_req_r;      // enhanced_status_required
  logic [`FRC_ROW_W-1:0]   row_r;          // row address being gathered
  logic [7:0]              byte_r;         // address byte awaiting store
  logic [1:0]              cyc_cnt_r;      // row cycles stored so far
  logic                    rb_s1, rb_s2, rb_s3; // pin synchroniser
  logic                    rb_lvl_r;       // accepted ready/busy level
  logic                    exit_nxt;       // hand-off this cycle
  frc_pkg::frc_exit_t      exit_code_nxt;  // hand-off target
  logic                    statout;        // status_output_flag

  assign statout = rif.status_output_flag;

  // true when the next store completes the row address
  function automatic logic last_row_cycle(input logic [1:0] cnt);
    last_row_cycle = (cnt == (`FRC_ROW_CYCLES - 2'd1));
  endfunction : last_row_cycle

  // place one address byte into the row at its cycle position
  function automatic logic [`FRC_ROW_W-1:0] put_byte(
    input logic [`FRC_ROW_W-1:0] row,
    input logic [1:0]            cnt,
    input logic [7:0]            b
  );
    logic [`FRC_ROW_W-1:0] r;
    r = row;
    case (cnt)
      2'd0:    r[7:0]   = b;
      2'd1:    r[15:8]  = b;
      default: r[23:16] = b;
    endcase
    put_byte = r;
  endfunction : put_byte

  // pin sync: a change counts only once stages two and three agree
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rb_s1    <= 1'b1;
      rb_s2    <= 1'b1;
      rb_s3    <= 1'b1;
      rb_lvl_r <= 1'b1;
    end else begin
      rb_s1 <= rb_pin;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
      if (rb_s2 == rb_s3) rb_lvl_r <= rb_s3;
    end
  end

  // next state and hand-off decode; one host event per cycle assumed,
  // commands are looked at before reads; in the column wait an address goes first
  always_comb begin
    state_nxt     = state_r;
    exit_nxt      = 1'b0;
    exit_code_nxt = frc_pkg::EX_NONE;
    case (state_r)
      frc_pkg::ST_IDLE: begin
        if (enter_col_wait) begin
          state_nxt = frc_pkg::ST_COL_WAIT;
        end else if (enter_dout_wait) begin
          state_nxt = frc_pkg::ST_DOUT_WAIT;
        end else if (host_cmd_valid && host_byte == `FRC_CMD_ERASE) begin
          state_nxt = frc_pkg::ST_ER_EXEC;
        end
      end
      frc_pkg::ST_COL_WAIT: begin
        if (host_addr_valid) begin
          state_nxt = frc_pkg::ST_ROW_STORE;                 // [R1]
        end else if (host_cmd_valid || host_data_valid) begin
          // other exits of this wait belong to the column change logic
          state_nxt     = frc_pkg::ST_IDLE;
          exit_nxt      = 1'b1;
          exit_code_nxt = frc_pkg::EX_COL_OTHER;
        end
      end
      frc_pkg::ST_ROW_WAIT: begin
        if (host_addr_valid) state_nxt = frc_pkg::ST_ROW_STORE;  // [R2]
      end
      frc_pkg::ST_ROW_STORE: begin
        if (last_row_cycle(cyc_cnt_r)) state_nxt = frc_pkg::ST_ROW_REQ; // [R3]
        else                           state_nxt = frc_pkg::ST_ROW_WAIT; // [R3]
      end
      frc_pkg::ST_ROW_REQ: begin
        // unconditional move on to the program data wait
        state_nxt     = frc_pkg::ST_IDLE;
        exit_nxt      = 1'b1;
        exit_code_nxt = frc_pkg::EX_PROG_DATA;               // [R4]
      end
      frc_pkg::ST_DOUT_WAIT: begin
        exit_nxt  = 1'b1;
        state_nxt = frc_pkg::ST_IDLE;
        if (host_cmd_valid) begin
          case (host_byte)                                   // [R8]
            `FRC_CMD_STATUS:  exit_code_nxt = frc_pkg::EX_READ_STAT;
            `FRC_CMD_ENHSTAT: exit_code_nxt = frc_pkg::EX_ENH_STAT;
            `FRC_CMD_READ:    exit_code_nxt = frc_pkg::EX_READ_EXEC;
            default:          exit_code_nxt = frc_pkg::EX_PROG_ILV;
          endcase
        end else if (host_read_req && statout) begin
          exit_code_nxt = frc_pkg::EX_STATUS_OUT;            // [R7]
        end else if (host_read_req && !enh_req_r) begin
          exit_code_nxt = frc_pkg::EX_UNIT_DATA;             // [R7]
        end else begin
          // a unit data read while the enhanced status is owed is held off here
          exit_nxt  = 1'b0;
          state_nxt = frc_pkg::ST_DOUT_WAIT;
        end
      end
      frc_pkg::ST_ER_EXEC: begin
        if (host_addr_valid) state_nxt = frc_pkg::ST_ER_STORE;   // [R10]
      end
      frc_pkg::ST_ER_STORE: begin
        if (last_row_cycle(cyc_cnt_r)) state_nxt = frc_pkg::ST_ER_UNIT; // [R12]
        else                           state_nxt = frc_pkg::ST_ER_EXEC; // [R12]
      end
      frc_pkg::ST_ER_UNIT: begin
        state_nxt = frc_pkg::ST_ER_CONFIRM;                  // [R14]
      end
      frc_pkg::ST_ER_CONFIRM: begin
        // anything but the two confirm codes is ignored
        if (host_cmd_valid && (host_byte == `FRC_CMD_ERASE_GO ||
                               host_byte == `FRC_CMD_ERASE_ILV)) begin
          state_nxt = frc_pkg::ST_ER_PASS;                   // [R15]
        end
      end
      frc_pkg::ST_ER_PASS: begin
        if (cmd_last_r == `FRC_CMD_ERASE_ILV) begin
          state_nxt = frc_pkg::ST_ER_ILV;                    // [R16]
        end else begin
          state_nxt     = frc_pkg::ST_IDLE;                  // [R16]
          exit_nxt      = 1'b1;
          exit_code_nxt = frc_pkg::EX_IDLE;
        end
      end
      frc_pkg::ST_ER_ILV: begin
        if (host_cmd_valid && host_byte == `FRC_CMD_ERASE) begin
          state_nxt = frc_pkg::ST_ER_EXEC;                   // [R18]
        end else if (host_cmd_valid && host_byte == `FRC_CMD_STATUS) begin
          state_nxt     = frc_pkg::ST_IDLE;                  // [R19]
          exit_nxt      = 1'b1;
          exit_code_nxt = frc_pkg::EX_READ_STAT;
        end else if (host_cmd_valid && host_byte == `FRC_CMD_ENHSTAT) begin
          state_nxt     = frc_pkg::ST_IDLE;                  // [R19]
          exit_nxt      = 1'b1;
          exit_code_nxt = frc_pkg::EX_ENH_STAT;
        end else if (!host_cmd_valid && host_read_req && statout) begin
          state_nxt     = frc_pkg::ST_IDLE;                  // [R20]
          exit_nxt      = 1'b1;
          exit_code_nxt = frc_pkg::EX_STATUS_OUT;
        end
      end
      default: begin
        state_nxt = frc_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) state_r <= frc_pkg::ST_IDLE;
    else         state_r <= state_nxt;
  end

  // hand-off pulse, registered so that it is glitch free
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      exit_valid <= 1'b0;
      exit_code  <= 4'h0;
    end else begin
      exit_valid <= exit_nxt;
      exit_code  <= exit_code_nxt;
    end
  end

  // return state is written while the wait state is occupied
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ret_r <= frc_pkg::ST_IDLE;
    end else if (state_r == frc_pkg::ST_DOUT_WAIT) begin
      ret_r <= frc_pkg::ST_DOUT_WAIT;                        // [R6]
    end else if (state_r == frc_pkg::ST_ER_ILV) begin
      ret_r <= frc_pkg::ST_ER_ILV;                           // [R17]
    end
  end

  // last command: 60h on entering erase, confirm code when accepted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_last_r <= `FRC_RST_CMD;
    end else if (state_nxt == frc_pkg::ST_ER_EXEC && state_r != frc_pkg::ST_ER_STORE) begin
      cmd_last_r <= `FRC_CMD_ERASE;                          // [R10]
    end else if (state_nxt == frc_pkg::ST_ER_PASS) begin
      cmd_last_r <= host_byte;
    end
  end

  // enhanced status owed: set on erase entry while busy; the set wins
  // over a software clear arriving in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enh_req_r <= 1'b0;
    end else if (state_nxt == frc_pkg::ST_ER_EXEC && !rb_lvl_r) begin
      enh_req_r <= 1'b1;                                     // [R11]
    end else if (rif.enh_clr) begin
      enh_req_r <= 1'b0;
    end
  end

  // row address gathering; the count restarts at each new sequence
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      byte_r    <= 8'h00;
      row_r     <= 24'h00_0000;
      cyc_cnt_r <= 2'd0;
    end else begin
      if (host_addr_valid) byte_r <= host_byte;
      if (state_r == frc_pkg::ST_ROW_STORE || state_r == frc_pkg::ST_ER_STORE) begin
        row_r     <= put_byte(row_r, cyc_cnt_r, byte_r);     // [R3] [R12]
        cyc_cnt_r <= last_row_cycle(cyc_cnt_r) ? 2'd0 : cyc_cnt_r + 2'd1;
      end else if (state_r == frc_pkg::ST_IDLE || state_r == frc_pkg::ST_ER_ILV) begin
        cyc_cnt_r <= 2'd0;
      end
    end
  end

  // unit selection from the erase row; a program row change keeps it,
  // relying on the host not to move unit or interleave address [R5]
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      unit_r <= 2'd0;
    end else if (state_r == frc_pkg::ST_ER_UNIT) begin
      unit_r <= row_r[`FRC_UNIT_LSB +: `FRC_UNIT_W];          // [R13]
    end
  end

  // requests to the units, one cycle each, from flip-flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      unit_row_change_req <= 1'b0;
      unit_erase_req      <= 1'b0;
      unit_cmd_pass       <= 1'b0;
      unit_cmd            <= 8'h00;
      unit_row_addr       <= 24'h00_0000;
    end else begin
      unit_row_change_req <= (state_r == frc_pkg::ST_ROW_REQ);  // [R4]
      unit_erase_req      <= (state_r == frc_pkg::ST_ER_UNIT);  // [R14]
      unit_cmd_pass       <= (state_r == frc_pkg::ST_ER_PASS);  // [R16]
      if (state_r == frc_pkg::ST_ER_PASS) unit_cmd <= cmd_last_r;
      if (state_r == frc_pkg::ST_ROW_REQ || state_r == frc_pkg::ST_ER_UNIT) begin
        unit_row_addr <= row_r;
      end
    end
  end

  // the unit port shows the unit picked by the last erase
  assign unit_sel = (state_r == frc_pkg::ST_ER_UNIT) ?
                    row_r[`FRC_UNIT_LSB +: `FRC_UNIT_W] : unit_r;
  assign busy     = (state_r != frc_pkg::ST_IDLE);

  // state seen by software
  assign rif.state                    = state_r;
  assign rif.saved_return_state       = ret_r;
  assign rif.last_command_code        = cmd_last_r;
  assign rif.selected_unit_index      = unit_r;
  assign rif.enhanced_status_required = enh_req_r;
  assign rif.rb_level                 = rb_lvl_r;
  assign rif.row_addr                 = row_r;

  // register bank on the wishbone bus
  frc_regs u_regs (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .rif      (rif.regs)
  );

endmodule : frc_ctrl

// ---- tb/frc_ctrl_properties.sv ----
// assertion checker on the controller ports
`timescale 1ns/10ps
module frc_ctrl_properties (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       host_cmd_valid,
  input wire logic [7:0] host_byte,
  input wire logic       enter_col_wait,
  input wire logic       enter_dout_wait,
  input wire logic       busy,
  input wire logic       unit_erase_req,
  input wire logic       unit_row_change_req,
  input wire logic       unit_cmd_pass,
  input wire logic [7:0] unit_cmd,
  input wire logic       exit_valid,
  input wire logic [3:0] exit_code,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // entry ports win over 60h, so they are excluded
  a_erase_entry: assert property (!busy && host_cmd_valid && host_byte == 8'h60 &&
    !enter_col_wait && !enter_dout_wait |=> busy) else $error("erase not entered");
  a_confirm_code: assert property (unit_cmd_pass |-> unit_cmd inside {8'hd0, 8'hd1})
    else $error("bad confirm passed");
  a_d0_idle: assert property (unit_cmd_pass && unit_cmd == 8'hd0 |-> exit_valid &&
    exit_code == 4'h1) else $error("d0 did not end erase");
  a_d1_stay: assert property (unit_cmd_pass && unit_cmd == 8'hd1 |-> busy &&
    !exit_valid) else $error("d1 left the block");
  a_erase_hold: assert property (unit_erase_req |-> busy [*2])
    else $error("confirm wait skipped");
  a_req_cause: assert property ($rose(unit_erase_req) |-> $past(busy))
    else $error("erase request from idle");
  a_row_exit: assert property (unit_row_change_req |-> exit_valid && exit_code == 4'h2)
    else $error("row change not followed by data wait");
  a_exit_idle: assert property (exit_valid |-> !busy)
    else $error("hand-off while busy");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule : frc_ctrl_properties

bind frc_ctrl frc_ctrl_properties frc_ctrl_properties_inst (.*);

// ---- tb/frc_host_model.sv ----
// host side: turns one go pulse into one command, address, read or data cycle
`timescale 1ns/10ps
module frc_host_model (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [1:0] kind,
  input  wire logic [7:0] byte_in,
  output logic            host_cmd_valid,
  output logic            host_addr_valid,
  output logic            host_read_req,
  output logic            host_data_valid,
  output logic [7:0]      host_byte
);
  // the scripted host keeps the unit bits on row change
  // it sends d0h or d1h after each erase row
  // it sends one read while the flag is owed, then reads unit data after a flag clear
  always @(posedge ref_clk) begin
    host_cmd_valid  <= go && kind == 2'h0;
    host_addr_valid <= go && kind == 2'h1;
    host_read_req   <= go && kind == 2'h2;
    host_data_valid <= go && kind == 2'h3;
    // a released bus does not keep its last byte
    host_byte       <= go ? byte_in : ~host_byte;
  end
endmodule : frc_host_model

// ---- tb/tb_flash_target_row_change_erase_fsm.sv ----
// bench for the erase and row change controller
`timescale 1ns/10ps
module tb_flash_target_row_change_erase_fsm;
  logic ref_clk = 0, resetn = 0, go = 0, rb_pin = 1, enter_col_wait = 0, enter_dout_wait = 0;
  logic [1:0] kind = 0, unit_sel;
  logic [7:0] byte_in = 0, host_byte, unit_cmd, wb_adr_i = 0;
  logic host_cmd_valid, host_addr_valid, host_data_valid, host_read_req, busy, exit_valid;
  logic unit_row_change_req, unit_erase_req, unit_cmd_pass, wb_ack_o;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_sel_i = 4'hf, exit_code, last_exit;
  logic [23:0] unit_row_addr, er_row, rc_row;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [1:0] er_sel;
  logic [7:0] pass_cmd;
  int err_count = 0, num_checks = 0, n_exit = 0, n_er = 0, n_pass = 0;
  logic [1:0] kd [6] = '{0, 0, 0, 0, 2, 2};
  logic [7:0] bt [6] = '{8'h70, 8'h78, 8'h00, 8'h11, 8'h00, 8'h00};
  logic [3:0] ex [6] = '{4'h6, 4'h7, 4'h8, 4'h3, 4'h4, 4'h5};
  always #2 ref_clk = ~ref_clk;
  frc_ctrl frc_ctrl_inst (.*);
  frc_host_model frc_host_model_inst (.*);
  // capture one-cycle pulses so tasks can judge them later
  always @(posedge ref_clk) begin
    if (exit_valid) begin n_exit <= n_exit + 1; last_exit <= exit_code; end
    if (unit_erase_req) begin n_er <= n_er + 1; er_row <= unit_row_addr; er_sel <= unit_sel; end
    if (unit_cmd_pass) begin n_pass <= n_pass + 1; pass_cmd <= unit_cmd; end
    if (unit_row_change_req) rc_row <= unit_row_addr;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin err_count++; $display("Error %s expected %h seen %h", nm, e, g); end
  endtask : chk
  // one host cycle, then a gap so addresses start three cycles apart
  task automatic hc(input logic [1:0] k, input logic [7:0] b);
    @(posedge ref_clk); go <= 1; kind <= k; byte_in <= b;
    @(posedge ref_clk); go <= 0;
    @(posedge ref_clk);
  endtask : hc
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk); wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    q = wb_dat_o; wb_cyc_i <= 0; wb_stb_i <= 0;
  endtask : wb
  task automatic wx(input logic [3:0] e);
    int c0;
    c0 = n_exit;
    repeat (30) if (n_exit == c0) @(posedge ref_clk);
    chk("exit_code", e, last_exit); chk("exit_count", c0 + 1, n_exit);
  endtask : wx
  task automatic pulse_dout;
    @(posedge ref_clk); enter_dout_wait <= 1;
    @(posedge ref_clk); enter_dout_wait <= 0;
  endtask : pulse_dout
  task automatic er(input logic [23:0] row, input logic [7:0] cf, input logic enh);
    int e0, p0;
    e0 = n_er; p0 = n_pass;
    hc(0, 8'h60); hc(1, row[7:0]); hc(1, row[15:8]); hc(1, row[23:16]);
    wb(0, 8'h04, 0); chk("last_cmd", 8'h60, q[19:12]);
    chk("enh_flag", enh, q[22]);
    // the pulse capture lands in this edge's update, so look one edge later
    @(posedge ref_clk);
    chk("erase_row", row, er_row); chk("erase_cnt", e0 + 1, n_er);
    chk("erase_unit", row[23:22], er_sel);
    hc(0, 8'h11); chk("wait_busy", 1, busy);
    hc(0, cf); repeat (3) @(posedge ref_clk);
    chk("pass_cmd", cf, pass_cmd); chk("pass_cnt", p0 + 1, n_pass);
    if (cf == 8'hd0) chk("exit_code", 1, last_exit);
    else chk("ilv_busy", 1, busy);
  endtask : er
  task final_report;
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1;
    er(24'hc54321, 8'hd0, 0);
    er(24'h402010, 8'hd1, 0);
    wb(0, 8'h04, 0); chk("state", 12'h800, q[11:0]);
    wb(0, 8'h08, 0); chk("ret_state", 12'h800, q[11:0]);
    er(24'h812345, 8'hd1, 0); hc(0, 8'h70); wx(4'h6);
    er(24'h000001, 8'hd1, 0); hc(0, 8'h78); wx(4'h7);
    er(24'h4000ff, 8'hd1, 0); wb(1, 8'h00, 1); hc(2, 0); wx(4'h4);
    for (int i = 0; i < 6; i++) begin
      pulse_dout;
      wb(0, 8'h08, 0); chk("ret_state", 12'h020, q[11:0]);
      wb(1, 8'h00, {31'h0, i == 4});
      hc(kd[i], bt[i]); wx(ex[i]);
    end
    // row change keeps unit 1 from the last erase: top byte bits 7:6 are 01
    @(posedge ref_clk); enter_col_wait <= 1;
    @(posedge ref_clk); enter_col_wait <= 0;
    hc(1, 8'h11); hc(1, 8'h22); hc(1, 8'h73); wx(4'h2);
    chk("row_change", 24'h732211, rc_row);
    chk("row_unit", 1, unit_sel);
    // a data byte leaves the column wait to the column change logic
    @(posedge ref_clk); enter_col_wait <= 1;
    @(posedge ref_clk); enter_col_wait <= 0;
    hc(3, 8'h5a); wx(4'h9);
    rb_pin <= 0; repeat (5) @(posedge ref_clk);
    er(24'h00c000, 8'hd0, 1);
    rb_pin <= 1; pulse_dout; hc(2, 0); repeat (4) @(posedge ref_clk);
    chk("read_held", 1, busy);
    wb(1, 8'h00, 32'h2); hc(2, 0); wx(4'h5);
    final_report;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    final_report;
  end
endmodule : tb_flash_target_row_change_erase_fsm
